/* File: core/ssp_device.sv */
`timescale 1ns/1ps
module ssp_device
	import ssp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Link to the host
	ssp_link_if.dev link,
	// Decoder core side
	input wire logic frameDone,
	input wire logic needInput,
	input wire logic [1:0] frameVersion,
	input wire logic [1:0] frameLayer,
	input wire logic frameCrcBad,
	input wire logic [1:0] frameRate,
	input wire logic [1:0] frameDeemp,
	input wire logic [AUDIO_BITS-1:0] audioSample,
	input wire logic monitorReady,
	input wire logic [2:0] swFormat,
	input wire logic swFormatLoad,
	output logic bitValid,
	output logic bitValue,
	output logic [STRAP_W-1:0] activeConfig,
	output logic layer3Enabled,
	output logic layer2Enabled,
	output logic refClockHigh,
	output logic clockScalerFixed,
	output logic broadcastMode,
	output logic [1:0] dacClockDivLog2,
	output logic sampleTaken
);
	logic [PORT_W-1:0] portS1_q, portS2_q;
	logic [2:0] sicSync_q;
	logic [1:0] sidSync_q;
	logic [3:0] encSync_q;
	logic strapDone_q, strapDone_d;
	logic [STRAP_W-1:0] cfg_q, pending_q;
	logic [PORT_W-1:0] status_q;
	logic syncFlag_q;
	logic [2:0] fmt_q;
	logic [5:0] bitCnt_q;
	logic [1:0] div_q;
	logic sclk_q, ws_q, sdo_q;
	logic [31:0] shift_q;
	logic bitValid_q, bitValue_q;
	wire sicFall, enablesOn, runApply, readAck, tick, slotLong, wsInv, dly, slotEnd, widthStrap;
	wire [5:0] slotLast;

	// Command bus and bitstream input work only while both power-up inputs are high
	assign enablesOn = link.converterEnable && link.decoderPowerEnable;
	assign link.supplyGood = link.converterEnable;
	assign link.converterReady = link.converterEnable;
	assign link.busAlive = enablesOn;
	assign runApply = enablesOn && link.cmdValid && link.cmdRunEntry == RUN_APPLY_CFG;
	assign readAck = enablesOn && link.cmdValid && link.cmdReadCtrl;

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge mclk) begin
		portS1_q <= link.portIn;
		portS2_q <= portS1_q;
		sicSync_q <= {sicSync_q[1], sicSync_q[0], link.bitstreamClock};
		sidSync_q <= {sidSync_q[0], link.bitstreamData};
	end
	assign sicFall = sicSync_q[2] && !sicSync_q[1];

	// Bitstream sample on falling clock edge, ident must be low
	always_ff @(posedge mclk) begin
		if (rst) begin
			bitValid_q <= 1'b0;
			bitValue_q <= 1'b0;
		end else begin
			bitValid_q <= sicFall && enablesOn && !link.bitstreamIdentInput;
			if (sicFall) begin
				bitValue_q <= sidSync_q[1];
			end
		end
	end
	assign bitValid = bitValid_q;
	assign bitValue = bitValue_q;

	// Strap capture one cycle after reset release, then output mode
	assign strapDone_d = 1'b1;
	always_ff @(posedge mclk) begin
		if (rst) begin
			strapDone_q <= 1'b0;
			cfg_q <= STRAP_RESET;
			pending_q <= STRAP_RESET;
		end else begin
			strapDone_q <= strapDone_d;
			if (!strapDone_q) begin
				cfg_q <= portS2_q[STRAP_W-1:0];
			end else if (runApply) begin
				cfg_q <= pending_q;
			end
			if (enablesOn && link.cmdValid && link.cmdWriteCfg) begin
				pending_q <= link.cmdCfg;
			end
		end
	end
	assign activeConfig = cfg_q;
	assign broadcastMode = cfg_q[STRAP_INMODE];
	assign layer2Enabled = !cfg_q[STRAP_L2DIS];
	assign layer3Enabled = !cfg_q[STRAP_L3DIS];
	assign refClockHigh = cfg_q[STRAP_REFSEL];
	assign clockScalerFixed = cfg_q[STRAP_SCALER];
	// Scaler: divide by 1, 2, 4 for version 1, 2, 2.5
	assign dacClockDivLog2 = cfg_q[STRAP_SCALER] ? 2'h0 :
		(status_q[PS_VER +: 2] == VER_V1 ? 2'h0 :
		(status_q[PS_VER +: 2] == VER_V2 ? 2'h1 : 2'h2));

	// Drive port only after capture and in host mode
	genvar g;
	for (g = 0; g < PORT_W; g++) begin : gOe
		assign link.portOeN[g] = !(strapDone_q && link.pioReadSelect && !link.pioChipSelectN);
	end
	assign link.portOut = {status_q[PORT_W-1:PS_SYNC+1], syncFlag_q, status_q[PS_SYNC-1:0]};

	// Status fields latch together per decoded frame; the demand line follows needInput every cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			status_q[PS_DEMAND] <= needInput;
			if (frameDone) begin
				status_q[PS_VER +: 2] <= frameVersion;
				status_q[PS_LAYER +: 2] <= frameLayer;
				status_q[PS_CRC] <= frameCrcBad || frameLayer == LAY_L1;
				status_q[PS_RATE +: 2] <= frameRate;
				status_q[PS_DEEMP +: 2] <= frameDeemp;
			end
		end
	end

	// Header-done flag: a new frame wins over a read
	always_ff @(posedge mclk) begin
		if (rst) begin
			syncFlag_q <= 1'b0;
		end else if (frameDone) begin
			syncFlag_q <= 1'b1;
		end else if (readAck) begin
			syncFlag_q <= 1'b0;
		end
	end

	// Output format: bit0 long slot, bit1 strobe inverted, bit2 delay
	always_ff @(posedge mclk) begin
		if (rst || !strapDone_q) begin
			fmt_q <= 3'h0;
		end else if (swFormatLoad) begin
			fmt_q <= swFormat;
		end else if (runApply || strapDone_q && !encSync_q[0]) begin
			fmt_q <= widthStrap ? 3'h4 : 3'h3;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			encSync_q <= 4'h0;
		end else if (swFormatLoad) begin
			encSync_q <= 4'h1;
		end else if (strapDone_q) begin
			encSync_q[0] <= 1'b1;
		end
	end
	assign slotLong = fmt_q[0];
	assign wsInv = fmt_q[1];
	assign dly = fmt_q[2];
	// Apply takes the width from the configuration being applied
	assign widthStrap = runApply ? pending_q[STRAP_WIDTH] : cfg_q[STRAP_WIDTH];
	assign slotLast = slotLong ? 6'(SLOT_LONG - 1) : 6'(SLOT_SHORT - 1);

	// Serial clock divider gives one-cycle enable
	assign tick = div_q == 2'(SCLK_HALF - 1);
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_q <= 2'h0;
			sclk_q <= 1'b0;
		end else begin
			div_q <= tick ? 2'h0 : div_q + 2'h1;
			if (tick) begin
				sclk_q <= !sclk_q;
			end
		end
	end

	// Audio shifter on falling serial clock
	// Wrap on or past the last bit, so a mode change mid-slot ends it at once
	assign slotEnd = bitCnt_q >= slotLast;
	assign sampleTaken = tick && sclk_q && slotEnd && monitorReady;
	always_ff @(posedge mclk) begin
		if (rst) begin
			bitCnt_q <= 6'h00;
			ws_q <= 1'b0;
			sdo_q <= 1'b0;
			shift_q <= 32'h00000000;
		end else if (tick && sclk_q) begin
			bitCnt_q <= slotEnd ? 6'h00 : bitCnt_q + 6'h01;
			if (slotEnd) begin
				ws_q <= !ws_q;
				shift_q <= slotLong ? {audioSample, 12'h000} : {audioSample[AUDIO_BITS-1 -: 16],
					16'h0000};
			end else begin
				shift_q <= {shift_q[30:0], 1'b0};
			end
			sdo_q <= dly ? shift_q[31] : (slotEnd ? audioSample[AUDIO_BITS-1] : shift_q[30]);
		end
	end
	assign link.wordStrobe = ws_q ^ wsInv;
	assign link.audioSerialOut = sdo_q;
	assign link.serialClock = sclk_q;
endmodule

/* File: core/ssp_pkg.sv */
package ssp_pkg;
	// Strap field positions inside the start-up configuration word
	localparam int STRAP_W = 6;
	localparam int STRAP_INMODE = 0;
	localparam int STRAP_WIDTH = 1;
	localparam int STRAP_L2DIS = 2;
	localparam int STRAP_L3DIS = 3;
	localparam int STRAP_REFSEL = 4;
	localparam int STRAP_SCALER = 5;
	localparam logic [5:0] STRAP_RESET = 6'h00;
	// Status port line layout
	localparam int PORT_W = 12;
	localparam int PS_DEMAND = 0;
	localparam int PS_VER = 1;
	localparam int PS_LAYER = 3;
	localparam int PS_CRC = 5;
	localparam int PS_SYNC = 6;
	localparam int PS_RATE = 7;
	localparam int PS_DEEMP = 9;
	localparam int PS_SPARE = 11;
	// Encodings
	localparam logic [1:0] VER_V25 = 2'h0;
	localparam logic [1:0] VER_V2 = 2'h2;
	localparam logic [1:0] VER_V1 = 2'h3;
	localparam logic [1:0] LAY_L3 = 2'h1;
	localparam logic [1:0] LAY_L2 = 2'h2;
	localparam logic [1:0] LAY_L1 = 2'h3;
	localparam logic [1:0] RATE_441 = 2'h0;
	localparam logic [1:0] RATE_48 = 2'h1;
	localparam logic [1:0] RATE_32 = 2'h2;
	localparam logic [1:0] DEEMP_NONE = 2'h0;
	localparam logic [1:0] DEEMP_5015 = 2'h1;
	localparam logic [1:0] DEEMP_J17 = 2'h3;
	// Run entry that applies a written configuration
	localparam logic [15:0] RUN_APPLY_CFG = 16'h0FCD;
	// Audio slot layout
	localparam int SLOT_SHORT = 16;
	localparam int SLOT_LONG = 32;
	localparam int AUDIO_BITS = 20;
	// Clock and divider: serial clock half period in mclk cycles
	localparam int MCLK_HZ = 10000000;
	localparam int SCLK_HALF = 2;
	// Host read deadline: half of the 24 ms shortest frame, 12 ms
	localparam int FRAME_MIN_US = 24000;
	localparam int READ_LIMIT_CYC = (FRAME_MIN_US / 2) * (MCLK_HZ / 1000000);
	// Apb register offsets of the host controller
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_CFG = 8'h08;
	localparam logic [7:0] REG_FIELDS = 8'h0C;
	localparam int CTRL_CONVERTER_ENABLE = 0;
	localparam int CTRL_APPLY = 1;
	localparam int CTRL_ACK = 2;
	localparam int CTRL_AUTO = 3;
	typedef enum logic [1:0] {PWR_OFF = 2'b00, PWR_CONV = 2'b01, PWR_UP = 2'b11} ssp_pwr_t;
endpackage

/* File: core/ssp_link_if.sv */
`timescale 1ns/1ps
interface ssp_link_if;
	import ssp_pkg::*;
	// Power sequencing
	logic converterEnable;
	logic decoderPowerEnable;
	logic supplyGood;
	logic converterReady;
	// Parallel port, three signals per line; oe low means driving
	logic [PORT_W-1:0] portIn;
	logic [PORT_W-1:0] portOut;
	logic [PORT_W-1:0] portOeN;
	logic pioReadSelect;
	logic pioChipSelectN;
	// Control command path (abstracted two-wire bus)
	logic cmdValid;
	logic [15:0] cmdRunEntry;
	logic cmdReadCtrl;
	logic cmdWriteCfg;
	logic [STRAP_W-1:0] cmdCfg;
	logic busAlive;
	// Bitstream and audio
	logic bitstreamClock;
	logic bitstreamData;
	logic bitstreamIdentInput;
	logic wordStrobe;
	logic audioSerialOut;
	logic serialClock;
	// Resolved port wire: device wins where it drives, host otherwise
	logic [PORT_W-1:0] portWire;
	logic [PORT_W-1:0] hostDrive;
	logic [PORT_W-1:0] hostOeN;
	genvar g;
	for (g = 0; g < PORT_W; g++) begin : gWire
		assign portWire[g] = !portOeN[g] ? portOut[g] : (!hostOeN[g] ? hostDrive[g] : 1'b0);
	end
	assign portIn = portWire;
	modport dev (input decoderPowerEnable, converterEnable, portIn, pioReadSelect,
		pioChipSelectN, cmdValid, cmdRunEntry, cmdReadCtrl, cmdWriteCfg, cmdCfg,
		bitstreamClock, bitstreamData, bitstreamIdentInput,
		output supplyGood, converterReady, portOut, portOeN, busAlive, wordStrobe,
		audioSerialOut, serialClock);
	modport host (output converterEnable, decoderPowerEnable, hostDrive, hostOeN,
		pioReadSelect, pioChipSelectN, cmdValid, cmdRunEntry, cmdReadCtrl, cmdWriteCfg,
		cmdCfg, bitstreamClock, bitstreamData, bitstreamIdentInput,
		input supplyGood, converterReady, portWire, busAlive, wordStrobe, audioSerialOut,
		serialClock);
endinterface

/* File: core/ssp_host.sv */
`timescale 1ns/1ps
module ssp_host
	import ssp_pkg::*;
#(
	parameter int READ_LIMIT = READ_LIMIT_CYC
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to the device
	ssp_link_if.host link,
	// Straps and bitstream from the system
	input wire logic [STRAP_W-1:0] strapLevels,
	input wire logic srcClock,
	input wire logic srcData
);
	logic [3:0] ctrl_q;
	logic [STRAP_W-1:0] cfg_q;
	logic [1:0] goodS_q, readyS_q, syncS_q;
	logic [PORT_W-1:0] portS1_q, portS2_q, fields_q;
	logic syncPrev_q, late_q, cmdValid_q, cmdRead_q, cmdWrite_q, cmdRun_q;
	logic [31:0] wait_q;
	ssp_pwr_t pwr_q;
	wire wr, rd, syncRise;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_STAT ||
		paddr == REG_CFG || paddr == REG_FIELDS);

	// Device pin synchronisers
	always_ff @(posedge mclk) begin
		goodS_q <= {goodS_q[0], link.supplyGood};
		readyS_q <= {readyS_q[0], link.converterReady};
		portS1_q <= link.portWire;
		portS2_q <= portS1_q;
		syncPrev_q <= portS2_q[PS_SYNC];
	end
	assign syncS_q = {syncPrev_q, portS2_q[PS_SYNC]};
	assign syncRise = syncS_q == 2'b01;

	// Power sequence: converter first, decoder after good and ready
	always_ff @(posedge mclk) begin
		if (rst || !ctrl_q[CTRL_CONVERTER_ENABLE]) begin
			pwr_q <= PWR_OFF;
		end else begin
			unique case (pwr_q)
				PWR_OFF: pwr_q <= PWR_CONV;
				PWR_CONV: if (goodS_q[1] && readyS_q[1]) pwr_q <= PWR_UP;
				PWR_UP: pwr_q <= PWR_UP;
				default: pwr_q <= PWR_OFF;
			endcase
		end
	end
	assign link.converterEnable = pwr_q != PWR_OFF;
	assign link.decoderPowerEnable = pwr_q == PWR_UP;

	// Straps driven until the decoder is powered up (PWR_UP), then released
	assign link.hostDrive = {{(PORT_W-STRAP_W){1'b0}}, strapLevels};
	assign link.hostOeN = {{(PORT_W-STRAP_W){1'b1}}, {STRAP_W{pwr_q == PWR_UP}}};
	assign link.pioReadSelect = 1'b1;
	assign link.pioChipSelectN = 1'b0;
	assign link.bitstreamIdentInput = 1'b0;
	assign link.bitstreamClock = srcClock;
	assign link.bitstreamData = srcData;

	// Register writes and command pulses
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= 4'h0;
			cfg_q <= STRAP_RESET;
			cmdValid_q <= 1'b0;
			cmdRead_q <= 1'b0;
			cmdWrite_q <= 1'b0;
			cmdRun_q <= 1'b0;
		end else begin
			cmdValid_q <= 1'b0;
			cmdRead_q <= 1'b0;
			cmdWrite_q <= 1'b0;
			cmdRun_q <= 1'b0;
			if (wr && paddr == REG_CTRL) begin
				ctrl_q <= {pwdata[CTRL_AUTO], 2'b00, pwdata[CTRL_CONVERTER_ENABLE]};
				cmdValid_q <= pwdata[CTRL_APPLY] || pwdata[CTRL_ACK];
				cmdRun_q <= pwdata[CTRL_APPLY];
				cmdRead_q <= pwdata[CTRL_ACK];
			end else if (wr && paddr == REG_CFG) begin
				cfg_q <= pwdata[STRAP_W-1:0];
				cmdValid_q <= 1'b1;
				cmdWrite_q <= 1'b1;
			end else if (ctrl_q[CTRL_AUTO] && syncRise) begin
				cmdValid_q <= 1'b1;
				cmdRead_q <= 1'b1;
			end
		end
	end
	assign link.cmdValid = cmdValid_q;
	assign link.cmdReadCtrl = cmdRead_q;
	assign link.cmdWriteCfg = cmdWrite_q;
	assign link.cmdRunEntry = cmdRun_q ? RUN_APPLY_CFG : 16'h0000;
	assign link.cmdCfg = cfg_q;

	// Fields snapshot and read deadline watch
	always_ff @(posedge mclk) begin
		if (rst) begin
			fields_q <= '0;
			wait_q <= 32'h00000000;
			late_q <= 1'b0;
		end else begin
			if (syncRise) begin
				fields_q <= portS2_q;
			end
			if (!syncS_q[0]) begin
				wait_q <= 32'h00000000;
			end else if (wait_q != 32'(READ_LIMIT)) begin
				wait_q <= wait_q + 32'h00000001;
			end else begin
				late_q <= 1'b1;
			end
		end
	end

	// Read mux
	always_comb begin
		prdata = 32'h00000000;
		if (rd && paddr == REG_CTRL) prdata = {28'h0000000, ctrl_q};
		if (rd && paddr == REG_STAT) prdata = {27'h0000000, late_q, link.busAlive,
			syncS_q[0], link.decoderPowerEnable, link.converterEnable};
		if (rd && paddr == REG_CFG) prdata = {26'h0000000, cfg_q};
		if (rd && paddr == REG_FIELDS) prdata = {20'h00000, fields_q};
	end
endmodule

/* File: sim/ssp_link_checker.sv */
`timescale 1ns/1ps
module ssp_link_checker
	import ssp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Power and command bus
	input wire logic converterEnable,
	input wire logic decoderPowerEnable,
	input wire logic supplyGood,
	input wire logic converterReady,
	input wire logic busAlive,
	input wire logic cmdValid,
	input wire logic cmdReadCtrl,
	// Parallel port
	input wire logic [PORT_W-1:0] portOut,
	input wire logic [PORT_W-1:0] portOeN,
	input wire logic pioReadSelect,
	input wire logic pioChipSelectN,
	// Bitstream
	input wire logic bitstreamIdentInput
);
	logic [1:0] relCnt_q;
	// Cycles since reset release, saturating
	always_ff @(posedge mclk) begin
		if (rst) relCnt_q <= 2'h0;
		else if (relCnt_q != 2'h3) relCnt_q <= relCnt_q + 2'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Steps of the status handshake
	sequence readAck;
		cmdValid && cmdReadCtrl && busAlive;
	endsequence
	sequence hostSelected;
		(relCnt_q == 2'h3 && pioReadSelect && !pioChipSelectN) [*2];
	endsequence
	chk_bus_gate: assert property (!(converterEnable && decoderPowerEnable) |-> !busAlive)
		else $error("command bus alive without both enables");
	chk_power_order: assert property ($rose(decoderPowerEnable) |->
		converterEnable && supplyGood && converterReady)
		else $error("decoder enabled before converter good");
	chk_strap_input: assert property ($past(rst) |-> &portOeN)
		else $error("port driven during strap capture");
	chk_port_drive: assert property (hostSelected |-> portOeN == '0)
		else $error("port not driven in host mode");
	chk_sync_clear: assert property (readAck |-> ##[1:3] !portOut[PS_SYNC])
		else $error("header flag not cleared by read");
	chk_fields_frame: assert property (relCnt_q != 2'h0 && $changed({portOut[PS_DEEMP+:2],
		portOut[PS_RATE+:2], portOut[PS_LAYER+:2], portOut[PS_VER+:2]}) |-> portOut[PS_SYNC])
		else $error("status fields changed outside a frame update");
	chk_cmd_pulse: assert property (cmdValid |=> !cmdValid)
		else $error("command strobe longer than one cycle");
	chk_ident_low: assert property (bitstreamIdentInput == 1'b0)
		else $error("bitstream identity input not low");
	chk_layer1_crc: assert property (!portOeN[PS_CRC] && portOut[PS_LAYER+:2] == LAY_L1
		|-> portOut[PS_CRC])
		else $error("layer 1 frame without error line");
endmodule

/* File: sim/ssp_test.sv */
`timescale 1ns/1ps
module ssp_test
	import ssp_pkg::*;
;
	// Clock, reset, counters
	logic mclk = 1'b0;
	logic rst = 1'b1;
	int errorCnt = 0;
	int comparisons = 0;
	// Apb master
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, sv;
	// System and decoder core side
	logic [STRAP_W-1:0] straps = 6'h2D;
	logic [STRAP_W-1:0] actCfg;
	logic srcClock = 1'b0, srcData = 1'b0, frameDone = 1'b0, needInput = 1'b0, crcBad = 1'b0;
	logic [1:0] fVer = 2'h0, fLay = 2'h0, fRate = 2'h0, fDeemp = 2'h0;
	logic bitValid, bitValue, l3En, l2En, refHi, scFix, bcast;
	logic [1:0] b4 = 2'h0, divLog2;
	logic [2:0] swFmt = 3'h0;
	logic swLoad = 1'b0;
	// Audio word fed to the device, and the field snapshot of the late frame
	localparam logic [19:0] SAMPLE = 20'hA5C3F;
	localparam logic [31:0] FIELDS_EXP = (32'h1 << PS_DEMAND) | (32'h1 << PS_VER) |
		(32'h1 << PS_LAYER) | (32'h1 << PS_SYNC) | (32'h1 << PS_RATE) | (32'h1 << PS_DEEMP);

	// Clock
	always #50 mclk = ~mclk;

	ssp_link_if link ();
	ssp_device ssp_device_i (.mclk(mclk), .rst(rst), .link(link.dev), .frameDone(frameDone),
		.needInput(needInput), .frameVersion(fVer), .frameLayer(fLay), .frameCrcBad(crcBad),
		.frameRate(fRate), .frameDeemp(fDeemp), .audioSample(SAMPLE), .monitorReady(1'b1),
		.swFormat(swFmt), .swFormatLoad(swLoad), .bitValid(bitValid), .bitValue(bitValue),
		.activeConfig(actCfg), .layer3Enabled(l3En), .layer2Enabled(l2En),
		.refClockHigh(refHi), .clockScalerFixed(scFix), .broadcastMode(bcast),
		.dacClockDivLog2(divLog2), .sampleTaken());
	ssp_host #(.READ_LIMIT(50)) ssp_host_i (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link.host), .strapLevels(straps),
		.srcClock(srcClock), .srcData(srcData));
	ssp_link_checker ssp_link_checker_i (.mclk(mclk), .rst(rst),
		.converterEnable(link.converterEnable), .decoderPowerEnable(link.decoderPowerEnable),
		.supplyGood(link.supplyGood), .converterReady(link.converterReady),
		.busAlive(link.busAlive), .cmdValid(link.cmdValid), .cmdReadCtrl(link.cmdReadCtrl),
		.portOut(link.portOut), .portOeN(link.portOeN), .pioReadSelect(link.pioReadSelect),
		.pioChipSelectN(link.pioChipSelectN), .bitstreamIdentInput(link.bitstreamIdentInput));

	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One decoded frame from the core
	task automatic frame(input logic [1:0] c, input logic crc, input logic dem);
		@(posedge mclk);
		{fVer, fLay, fRate, fDeemp} <= {c, c, c, c};
		crcBad <= crc;
		needInput <= dem;
		frameDone <= 1'b1;
		@(posedge mclk);
		frameDone <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	// One audio slot, bits taken at rising serial clock after a strobe edge
	task automatic slot(input int n, input int skip, output logic [31:0] v);
		logic ws0, ck0;
		int b;
		v = 32'h0;
		b = -skip;
		ws0 = link.wordStrobe;
		for (int k = 0; k < 300 && link.wordStrobe === ws0; k++) @(posedge mclk);
		while (b < n) begin
			ck0 = link.serialClock;
			@(posedge mclk);
			if (!ck0 && link.serialClock) begin
				if (b >= 0) v[31-b] = link.audioSerialOut;
				b++;
			end
		end
	endtask

	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, errorCnt);
		if (errorCnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		errorCnt++;
		end_sim();
	end

	// Test sequence
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("config", {26'h0, straps}, {26'h0, actCfg});
		chk("layer3", !straps[STRAP_L3DIS], l3En);
		chk("layer2", !straps[STRAP_L2DIS], l2En);
		chk("refclk", straps[STRAP_REFSEL], refHi);
		chk("scaler", straps[STRAP_SCALER], scFix);
		chk("inmode", straps[STRAP_INMODE], bcast);
		chk("divider", 2'h0, divLog2);
		slot(32, 0, sv);
		chk("slot32", {SAMPLE, 12'h000}, sv);
		$display("test straps done");
		apb(1'b1, REG_CTRL, 32'h1);
		for (int i = 0; i < 200 && rd[3] !== 1'b1; i++) apb(1'b0, REG_STAT, 32'h0);
		chk("enables", 2'h3, rd[1:0]);
		chk("bus alive", 1'b1, rd[3]);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 1'b1, err);
		$display("test power done");
		for (int i = 0; i < 4; i++) begin
			b4 = i[1:0];
			frame(b4, b4[1], b4[0]);
			chk("version", b4, link.portWire[PS_VER+:2]);
			chk("layer", b4, link.portWire[PS_LAYER+:2]);
			chk("rate", b4, link.portWire[PS_RATE+:2]);
			chk("deemph", b4, link.portWire[PS_DEEMP+:2]);
			chk("crc", b4[1] | (b4 == LAY_L1), link.portWire[PS_CRC]);
			chk("demand", b4[0], link.portWire[PS_DEMAND]);
			chk("sync set", 1'b1, link.portWire[PS_SYNC]);
			apb(1'b1, REG_CTRL, 32'h5);
			apb(1'b1, REG_CTRL, 32'h1);
			repeat (10) @(posedge mclk);
			chk("sync clear", 1'b0, link.portWire[PS_SYNC]);
		end
		frame(2'h1, 1'b0, 1'b1);
		repeat (60) @(posedge mclk);
		apb(1'b0, REG_STAT, 32'h0);
		chk("late", 1'b1, rd[4]);
		apb(1'b0, REG_FIELDS, 32'h0);
		chk("fields", FIELDS_EXP, rd);
		apb(1'b1, REG_CTRL, 32'h5);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_CTRL, 32'h9);
		frame(2'h2, 1'b0, 1'b0);
		repeat (10) @(posedge mclk);
		chk("auto clear", 1'b0, link.portWire[PS_SYNC]);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", 32'h9, rd);
		apb(1'b1, REG_CTRL, 32'h1);
		$display("test status done");
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			srcData <= (i != 1);
			srcClock <= 1'b1;
			repeat (3) @(posedge mclk);
			srcClock <= 1'b0;
			for (int k = 0; k < 10 && bitValid !== 1'b1; k++) @(posedge mclk);
			chk("bit valid", 1'b1, bitValid);
			chk("bit", (i != 1), bitValue);
			repeat (3) @(posedge mclk);
		end
		$display("test bitstream done");
		apb(1'b1, REG_CFG, 32'h12);
		apb(1'b1, REG_CTRL, 32'h3);
		for (int k = 0; k < 100 && actCfg !== 6'h12; k++) @(posedge mclk);
		chk("applied", 6'h12, actCfg);
		slot(16, 1, sv);
		chk("slot16", {SAMPLE[AUDIO_BITS-1 -: 16], 16'h0000}, sv);
		swFmt <= 3'h5;
		swLoad <= 1'b1;
		@(posedge mclk);
		swLoad <= 1'b0;
		slot(32, 1, sv);
		chk("slot soft", {SAMPLE, 12'h000}, sv);
		rst <= 1'b1;
		straps <= 6'h0A;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("reload", 6'h0A, actCfg);
		chk("divider", 2'h2, divLog2);
		$display("test reconfig done");
		end_sim();
	end
endmodule
